// ### hw/lpmc_ctrl.v
// low-power mode controller with AXI4-Lite registers
// Function
// - three voltage ranges cap the cpu clock at 32, 16 and 4.2 MHz.
// - sleep halts only the cpu clock and any peripheral interrupt wakes it.
// - low-power run uses the multispeed oscillator at 131 kHz or less, regulator low-power.
// - low-power sleep is sleep with a low-power regulator; wakeup returns to run, regulator on.
// - stop with rtc stops core clocks and fast oscillators, keeps one slow oscillator.
// - in stop a wakeup-capable peripheral may turn on the high-speed internal oscillator.
// - any enabled external interrupt line wakes from stop, cpu running within 3.5 us.
// - stop wakeup accepts pins, supply monitor, comparators with reference, serial and timer wakeups, and rtc in stop with rtc only.
// - stop without rtc stops every clock but a requested high-speed internal oscillator, including slow oscillators, retaining state.
// - standby powers off regulator and core, keeping only the standby circuitry.
// - standby with rtc exits within 60 us on reset, watchdog, wakeup pin rise or rtc event.
// - standby without rtc exits within 60 us only on reset pin, watchdog or wakeup pin rise.
// - stop with rtc and standby do not themselves halt rtc, watchdog or their oscillators.
// - flash wait states follow range and frequency thresholds.
`timescale 1ns/10ps
`default_nettype none
`include "lpmc_defines.vh"

module lpmc_ctrl #(
	parameter N_EXT         = 16,
	parameter STBY_WAKE_CYC = `LPMC_STBY_WAKE_CYC
)(
	input  wire             mclk,
	input  wire             rst,
	input  wire             ce,
	input  wire [7:0]       s_axi_awaddr,
	input  wire             s_axi_awvalid,
	output reg              s_axi_awready,
	input  wire [31:0]      s_axi_wdata,
	input  wire [3:0]       s_axi_wstrb,
	input  wire             s_axi_wvalid,
	output reg              s_axi_wready,
	output reg  [1:0]       s_axi_bresp,
	output reg              s_axi_bvalid,
	input  wire             s_axi_bready,
	input  wire [7:0]       s_axi_araddr,
	input  wire             s_axi_arvalid,
	output reg              s_axi_arready,
	output reg  [31:0]      s_axi_rdata,
	output reg  [1:0]       s_axi_rresp,
	output reg              s_axi_rvalid,
	input  wire             s_axi_rready,
	input  wire             cpu_wfi,
	input  wire             external_reset_pin_n,
	input  wire             independent_watchdog_rst,
	input  wire [N_EXT-1:0] external_interrupt_line,
	input  wire             supply_monitor_output,
	input  wire [1:0]       comparator_evt,
	input  wire [4:0]       periph_wake,
	input  wire             periph_hsi_req,
	input  wire [3:0]       rtc_evt,
	input  wire [2:0]       standby_wakeup_pin,
	input  wire             periph_irq,
	output reg              cpu_clk_en,
	output reg              periph_clk_en,
	output reg              pll_en,
	output reg              multispeed_internal_osc_en,
	output reg              multispeed_low_speed,
	output reg              high_speed_internal_osc_en,
	output reg              high_speed_crystal_osc_en,
	output reg              low_speed_internal_osc_en,
	output reg              low_speed_crystal_osc_en,
	output reg              regulator_on,
	output reg              regulator_low_power,
	output reg              core_power_on,
	output reg  [1:0]       voltage_range,
	output reg              flash_wait_state,
	output reg              cpu_reset,
	output reg  [2:0]       mode_status
);
	localparam [2:0] S_RUN     = 3'h0;
	localparam [2:0] S_SLEEP   = 3'h1;
	localparam [2:0] S_LPRUN   = 3'h2;
	localparam [2:0] S_LPSLEEP = 3'h3;
	localparam [2:0] S_STOPR   = 3'h4;
	localparam [2:0] S_STOP    = 3'h5;
	localparam [2:0] S_STBYR   = 3'h6;
	localparam [2:0] S_STBY    = 3'h7;
	localparam [31:0] STOP_CYC_W = `LPMC_STOP_WAKE_CYC;
	localparam [31:0] GAP_CYC_W  = `LPMC_STEP_GAP_CYC;
	localparam [15:0] STOP_CYC   = STOP_CYC_W[15:0];
	localparam [15:0] GAP_CYC    = GAP_CYC_W[15:0];

	reg  [2:0]       state_q;
	reg  [2:0]       req_q;
	reg              lprun_q;
	reg  [1:0]       range_q;
	reg  [15:0]      freq_khz_q;
	reg              lsi_keep_q;
	reg              lse_keep_q;
	reg  [N_EXT-1:0] ext_en_q;
	reg              int_ref_q;
	reg  [3:0]       cause_q;
	reg              freq_err_q;
	reg  [15:0]      gap_q;
	reg  [15:0]      wake_cnt_q;
	reg              waking_q;
	reg              aw_hold_q;
	reg              w_hold_q;
	reg  [7:0]       awaddr_q;
	reg  [31:0]      wdata_q;
	reg  [3:0]       wstrb_q;
	reg  [31:0]      rd_d;
	wire             wake;
	wire [3:0]       wake_cause;
	wire             range_fit;
	wire [31:0]      wr_data;
	wire [15:0]      new_freq;
	wire [15:0]      fmax;
	wire             step_ok;
	wire             stby_reset;
	wire [15:0]      wake_limit;

	lpmc_wake_select #(
		.N_EXT                 (N_EXT)
	) u_wake (
		.mclk                  (mclk),
		.rst                   (rst),
		.ce                    (ce),
		.mode                  (state_q),
		.ext_line              (external_interrupt_line),
		.ext_en                (ext_en_q),
		.supply_monitor_output (supply_monitor_output),
		.comparator_evt        (comparator_evt),
		.int_ref_on            (int_ref_q),
		.periph_wake           (periph_wake),
		.rtc_evt               (rtc_evt),
		.standby_wakeup_pin    (standby_wakeup_pin),
		.periph_irq            (periph_irq),
		.wake                  (wake),
		.cause                 (wake_cause)
	);

	// write channel: address and data taken in either order
	assign wr_data  = w_hold_q ? wdata_q : s_axi_wdata;
	assign new_freq = wr_data[15:0];

	assign fmax = (range_q == `LPMC_RANGE_1) ? 16'd`LPMC_FMAX_R1_KHZ
		: (range_q == `LPMC_RANGE_2) ? 16'd`LPMC_FMAX_R2_KHZ : 16'd`LPMC_FMAX_R3_KHZ;
	// less than 4x up or down, and spacing honoured; a refused step sets an error flag
	assign step_ok = (gap_q == 16'h0) & (new_freq <= fmax) & (new_freq != 16'h0)
		& ({2'b00, freq_khz_q} < {new_freq, 2'b00})
		& ({2'b00, new_freq} < {freq_khz_q, 2'b00})
		& (~lprun_q | (new_freq <= 16'd`LPMC_FMAX_LPRUN_KHZ));
	// range changes take effect only if the clock already fits the new range
	assign range_fit = (wdata_q[17:16] == `LPMC_RANGE_3) ? (freq_khz_q <= 16'd`LPMC_FMAX_R3_KHZ)
		: (wdata_q[17:16] != `LPMC_RANGE_2) | (freq_khz_q <= 16'd`LPMC_FMAX_R2_KHZ);

	// hardware standby exit by reset pin or watchdog
	assign stby_reset = ~external_reset_pin_n | independent_watchdog_rst;
	assign wake_limit = (state_q == S_STBYR || state_q == S_STBY) ? STBY_WAKE_CYC[15:0] : STOP_CYC;

	always @(posedge mclk)
	begin
		if (rst)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'h0;
			aw_hold_q     <= 1'b0;
			w_hold_q      <= 1'b0;
			awaddr_q      <= 8'h0;
			wdata_q       <= 32'h0;
			wstrb_q       <= 4'h0;
			req_q         <= `LPMC_REQ_SLEEP;
			lprun_q       <= 1'b0;
			range_q       <= `LPMC_RANGE_2;
			freq_khz_q    <= 16'd2097;
			lsi_keep_q    <= 1'b1;
			lse_keep_q    <= 1'b1;
			ext_en_q      <= {N_EXT{1'b1}};
			int_ref_q     <= 1'b1;
			freq_err_q    <= 1'b0;
			gap_q         <= 16'h0;
		end
		else if (ce)
		begin
			s_axi_awready <= ~aw_hold_q & ~s_axi_awready & s_axi_awvalid & ~s_axi_bvalid;
			s_axi_wready  <= ~w_hold_q & ~s_axi_wready & s_axi_wvalid & ~s_axi_bvalid;
			if (s_axi_awvalid & s_axi_awready)
			begin
				aw_hold_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end
			if (s_axi_wvalid & s_axi_wready)
			begin
				w_hold_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
			end
			if (gap_q != 16'h0)
				gap_q <= gap_q - 16'h1;
			if (aw_hold_q & w_hold_q & ~s_axi_bvalid)
			begin
				aw_hold_q    <= 1'b0;
				w_hold_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= 2'h0;
				if (wstrb_q[0])
				begin
					case (awaddr_q)
						`LPMC_ADDR_CTRL:
						begin
							req_q     <= wdata_q[2:0];
							lprun_q   <= wdata_q[4] & (freq_khz_q <= 16'd`LPMC_FMAX_LPRUN_KHZ);
							int_ref_q <= wdata_q[5];
						end
						`LPMC_ADDR_CLKSEL:
						begin
							if (wdata_q[17:16] != 2'h0 && wdata_q[17:16] != range_q)
							begin
								if (range_fit)
									range_q <= wdata_q[17:16];
								else
									freq_err_q <= 1'b1;
							end
							else if (step_ok)
							begin
								freq_khz_q <= wdata_q[15:0];
								gap_q      <= GAP_CYC;
							end
							else
								freq_err_q <= 1'b1;
						end
						`LPMC_ADDR_OSC:
						begin
							lsi_keep_q <= wdata_q[0];
							lse_keep_q <= wdata_q[1];
							if (wdata_q[2])
								freq_err_q <= 1'b0;
						end
						`LPMC_ADDR_WAKE_EN:
							ext_en_q <= wdata_q[N_EXT-1:0];
						`LPMC_ADDR_STATUS, `LPMC_ADDR_CAUSE: ;
						default:
							s_axi_bresp <= 2'h2;
					endcase
				end
			end
			if (s_axi_bvalid & s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	always @*
	begin
		rd_d = 32'h0;
		case (s_axi_araddr)
			`LPMC_ADDR_CTRL:    rd_d = {26'h0, int_ref_q, lprun_q, 1'b0, req_q};
			`LPMC_ADDR_STATUS:  rd_d = {24'h0, freq_err_q, flash_wait_state, voltage_range, 1'b0, state_q};
			`LPMC_ADDR_CLKSEL:  rd_d = {14'h0, range_q, freq_khz_q};
			`LPMC_ADDR_OSC:     rd_d = {30'h0, lse_keep_q, lsi_keep_q};
			`LPMC_ADDR_WAKE_EN: rd_d = {{(32-N_EXT){1'b0}}, ext_en_q};
			`LPMC_ADDR_CAUSE:   rd_d = {28'h0, cause_q};
			default:            rd_d = 32'h0;
		endcase
	end

	always @(posedge mclk)
	begin
		if (rst)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= 2'h0;
		end
		else if (ce)
		begin
			s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
			if (s_axi_arvalid & s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_d;
				s_axi_rresp  <= (s_axi_araddr[1:0] == 2'h0 && s_axi_araddr <= `LPMC_ADDR_CAUSE)
					? 2'h0 : 2'h2;
			end
			else if (s_axi_rvalid & s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// mode state machine
	always @(posedge mclk)
	begin
		if (rst)
		begin
			state_q    <= S_RUN;
			cause_q    <= 4'h0;
			waking_q   <= 1'b0;
			wake_cnt_q <= 16'h0;
		end
		else if (ce)
		begin
			case (state_q)
				S_RUN, S_LPRUN:
				begin
					state_q <= lprun_q ? S_LPRUN : S_RUN;
					if (cpu_wfi)
					begin
						case (req_q)
							`LPMC_REQ_SLEEP:    state_q <= S_SLEEP;
							`LPMC_REQ_LP_SLEEP: state_q <= S_LPSLEEP;
							`LPMC_REQ_STOP_RTC: state_q <= S_STOPR;
							`LPMC_REQ_STOP:     state_q <= S_STOP;
							`LPMC_REQ_STBY_RTC: state_q <= S_STBYR;
							`LPMC_REQ_STBY:     state_q <= S_STBY;
							default:            state_q <= S_SLEEP;
						endcase
					end
				end
				S_SLEEP, S_LPSLEEP:
				begin
					if (wake)
					begin
						state_q <= S_RUN;
						cause_q <= wake_cause;
					end
				end
				S_STOPR, S_STOP, S_STBYR, S_STBY:
				begin
					// ends two short so the registered cpu clock enable is back at the limit
					if (waking_q)
					begin
						if (wake_cnt_q >= wake_limit - 16'h2)
						begin
							waking_q   <= 1'b0;
							wake_cnt_q <= 16'h0;
							state_q    <= S_RUN;
						end
						else
							wake_cnt_q <= wake_cnt_q + 16'h1;
					end
					else if (wake | ((state_q == S_STBYR || state_q == S_STBY) & stby_reset))
					begin
						waking_q <= 1'b1;
						cause_q  <= {wake_cause[3:1], wake_cause[0] | stby_reset};
					end
				end
				default: state_q <= S_RUN;
			endcase
		end
	end

	// derived clock, oscillator and regulator controls
	always @(posedge mclk)
	begin
		if (rst)
		begin
			cpu_clk_en                 <= 1'b1;
			periph_clk_en              <= 1'b1;
			pll_en                     <= 1'b0;
			multispeed_internal_osc_en <= 1'b1;
			multispeed_low_speed       <= 1'b0;
			high_speed_internal_osc_en <= 1'b0;
			high_speed_crystal_osc_en  <= 1'b0;
			low_speed_internal_osc_en  <= 1'b1;
			low_speed_crystal_osc_en   <= 1'b1;
			regulator_on               <= 1'b1;
			regulator_low_power        <= 1'b0;
			core_power_on              <= 1'b1;
			voltage_range              <= `LPMC_RANGE_2;
			flash_wait_state           <= 1'b0;
			cpu_reset                  <= 1'b0;
			mode_status                <= `LPMC_MODE_RUN;
		end
		else if (ce)
		begin
			mode_status   <= state_q;
			voltage_range <= range_q;
			flash_wait_state <= ((range_q == `LPMC_RANGE_1) & (freq_khz_q > 16'd`LPMC_FWS_R1_KHZ))
				| ((range_q == `LPMC_RANGE_2) & (freq_khz_q > 16'd`LPMC_FWS_R2_KHZ));
			cpu_clk_en    <= (state_q == S_RUN) | (state_q == S_LPRUN);
			periph_clk_en <= state_q[2] == 1'b0;
			pll_en        <= ~state_q[2] & ~lprun_q;
			multispeed_internal_osc_en <= ~state_q[2];
			multispeed_low_speed <= (state_q == S_LPRUN) | (state_q == S_LPSLEEP);
			high_speed_crystal_osc_en  <= ~state_q[2] & ~lprun_q;
			high_speed_internal_osc_en <= ((state_q == S_STOPR) | (state_q == S_STOP))
				? periph_hsi_req : (~state_q[2] & ~lprun_q);
			// slow oscillators keep their own enable; only stop-without-rtc forces them off
			low_speed_internal_osc_en <= lsi_keep_q & (state_q != S_STOP);
			low_speed_crystal_osc_en  <= lse_keep_q & (state_q != S_STOP);
			regulator_on        <= ~(state_q == S_STBYR || state_q == S_STBY);
			core_power_on       <= ~(state_q == S_STBYR || state_q == S_STBY);
			regulator_low_power <= (state_q == S_LPRUN) | (state_q == S_LPSLEEP)
				| (state_q == S_STOPR) | (state_q == S_STOP);
			cpu_reset <= (state_q == S_STBYR || state_q == S_STBY);
		end
	end
endmodule // lpmc_ctrl

`default_nettype wire

// ### hw/lpmc_defines.vh
// constants for the low-power mode controller
`ifndef LPMC_DEFINES_VH
`define LPMC_DEFINES_VH

`define LPMC_ADDR_CTRL        8'h00
`define LPMC_ADDR_STATUS      8'h04
`define LPMC_ADDR_CLKSEL      8'h08
`define LPMC_ADDR_OSC         8'h0c
`define LPMC_ADDR_WAKE_EN     8'h10
`define LPMC_ADDR_CAUSE       8'h14

`define LPMC_REQ_SLEEP        3'h0
`define LPMC_REQ_LP_SLEEP     3'h1
`define LPMC_REQ_STOP_RTC     3'h2
`define LPMC_REQ_STOP         3'h3
`define LPMC_REQ_STBY_RTC     3'h4
`define LPMC_REQ_STBY         3'h5

`define LPMC_MODE_RUN         3'h0
`define LPMC_MODE_SLEEP       3'h1
`define LPMC_MODE_LP_RUN      3'h2
`define LPMC_MODE_LP_SLEEP    3'h3
`define LPMC_MODE_STOP_RTC    3'h4
`define LPMC_MODE_STOP        3'h5
`define LPMC_MODE_STBY_RTC    3'h6
`define LPMC_MODE_STBY        3'h7

`define LPMC_RANGE_1          2'h1
`define LPMC_RANGE_2          2'h2
`define LPMC_RANGE_3          2'h3

`define LPMC_FMAX_R1_KHZ      32000
`define LPMC_FMAX_R2_KHZ      16000
`define LPMC_FMAX_R3_KHZ      4200
`define LPMC_FWS_R1_KHZ       16000
`define LPMC_FWS_R2_KHZ       8000
`define LPMC_FMAX_LPRUN_KHZ   131

`define LPMC_CLK_MHZ          200
`define LPMC_STOP_WAKE_NS     3500
`define LPMC_STBY_WAKE_NS     60000
`define LPMC_STEP_GAP_NS      5000
`define LPMC_STOP_WAKE_CYC    ((`LPMC_STOP_WAKE_NS * `LPMC_CLK_MHZ) / 1000)
`define LPMC_STBY_WAKE_CYC    ((`LPMC_STBY_WAKE_NS * `LPMC_CLK_MHZ) / 1000)
`define LPMC_STEP_GAP_CYC     ((`LPMC_STEP_GAP_NS * `LPMC_CLK_MHZ + 999) / 1000)

`endif

// ### hw/lpmc_wake_select.v
// wakeup source qualification per low-power mode
`timescale 1ns/10ps
`default_nettype none
`include "lpmc_defines.vh"

module lpmc_wake_select #(
	parameter N_EXT = 16
)(
	input  wire             mclk,
	input  wire             rst,
	input  wire             ce,
	input  wire [2:0]       mode,
	input  wire [N_EXT-1:0] ext_line,
	input  wire [N_EXT-1:0] ext_en,
	input  wire             supply_monitor_output,
	input  wire [1:0]       comparator_evt,
	input  wire             int_ref_on,
	input  wire [4:0]       periph_wake,
	input  wire [3:0]       rtc_evt,
	input  wire [2:0]       standby_wakeup_pin,
	input  wire             periph_irq,
	output wire             wake,
	output wire [3:0]       cause
);
	reg  [2:0]       pin_q;
	wire [2:0]       pin_rise;
	wire [N_EXT-1:0] ext_hit;
	wire             stop_src;
	wire             stby_src;
	wire             sleep_src;

	always @(posedge mclk)
	begin
		if (rst)
			pin_q <= 3'h0;
		else if (ce)
			pin_q <= standby_wakeup_pin;
	end

	assign pin_rise = standby_wakeup_pin & ~pin_q;

	genvar i;
	generate
		for (i = 0; i < N_EXT; i = i + 1)
		begin : g_ext
			assign ext_hit[i] = ext_line[i] & ext_en[i];
		end
	endgenerate

	assign stop_src = (|ext_hit) | supply_monitor_output
		| ((|comparator_evt) & int_ref_on) | (|periph_wake)
		| ((mode == `LPMC_MODE_STOP_RTC) & (|rtc_evt));
	assign stby_src = (|pin_rise)
		| ((mode == `LPMC_MODE_STBY_RTC) & (|rtc_evt));
	assign sleep_src = periph_irq | stop_src;

	assign wake = ((mode == `LPMC_MODE_SLEEP) | (mode == `LPMC_MODE_LP_SLEEP)) ? sleep_src
		: ((mode == `LPMC_MODE_STOP_RTC) | (mode == `LPMC_MODE_STOP)) ? stop_src
		: ((mode == `LPMC_MODE_STBY_RTC) | (mode == `LPMC_MODE_STBY)) ? stby_src
		: 1'b0;
	assign cause = {|pin_rise, |rtc_evt, |ext_hit, periph_irq};
endmodule // lpmc_wake_select

`default_nettype wire

// ### test/lpmc_chk_assertions.sv
// port-level assertions for the low-power mode controller
`timescale 1ns/10ps
`default_nettype none
`include "lpmc_defines.vh"

module lpmc_chk #(
	parameter N_EXT         = 16,
	parameter STBY_WAKE_CYC = 50
)(
	input wire logic             mclk,
	input wire logic             rst,
	input wire logic             periph_irq,
	input wire logic [N_EXT-1:0] external_interrupt_line,
	input wire logic [2:0]       standby_wakeup_pin,
	input wire logic             periph_hsi_req,
	input wire logic             cpu_clk_en,
	input wire logic             periph_clk_en,
	input wire logic             pll_en,
	input wire logic             multispeed_internal_osc_en,
	input wire logic             multispeed_low_speed,
	input wire logic             high_speed_crystal_osc_en,
	input wire logic             high_speed_internal_osc_en,
	input wire logic             low_speed_internal_osc_en,
	input wire logic             low_speed_crystal_osc_en,
	input wire logic             regulator_on,
	input wire logic             regulator_low_power,
	input wire logic             core_power_on,
	input wire logic [1:0]       voltage_range,
	input wire logic             flash_wait_state,
	input wire logic             cpu_reset,
	input wire logic [2:0]       mode_status
);
	// one extra cycle for the output register
	localparam int STBY_LIM = STBY_WAKE_CYC + 1;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	sleep_clk_a:
		assert property (mode_status == `LPMC_MODE_SLEEP |-> !cpu_clk_en && periph_clk_en)
		else $error("sleep clock gating wrong");
	sleep_wake_a:
		assert property (mode_status inside {`LPMC_MODE_SLEEP, `LPMC_MODE_LP_SLEEP} && periph_irq
			|-> ##[1:4] mode_status == `LPMC_MODE_RUN && regulator_on && !regulator_low_power)
		else $error("sleep wake to run missing");
	lprun_osc_a:
		assert property (mode_status == `LPMC_MODE_LP_RUN
			|-> multispeed_internal_osc_en && multispeed_low_speed && regulator_low_power)
		else $error("low-power run clocking wrong");
	lpsleep_reg_a:
		assert property (mode_status == `LPMC_MODE_LP_SLEEP |-> regulator_low_power && !cpu_clk_en)
		else $error("low-power sleep regulator wrong");
	stop_osc_a:
		assert property (mode_status == `LPMC_MODE_STOP_RTC |-> !pll_en && regulator_low_power
			&& !multispeed_internal_osc_en && !high_speed_crystal_osc_en
			&& (low_speed_internal_osc_en || low_speed_crystal_osc_en))
		else $error("stop oscillators wrong");
	stop_clk_a:
		assert property (mode_status inside {`LPMC_MODE_STOP_RTC, `LPMC_MODE_STOP}
			|-> !cpu_clk_en && !periph_clk_en)
		else $error("stop clocks running");
	stop_wake_a:
		assert property (mode_status inside {`LPMC_MODE_STOP_RTC, `LPMC_MODE_STOP}
			&& |external_interrupt_line |-> ##[1:701] mode_status == `LPMC_MODE_RUN && cpu_clk_en)
		else $error("stop exit too slow");
	stop_hsi_a:
		assert property (mode_status inside {`LPMC_MODE_STOP_RTC, `LPMC_MODE_STOP}
			|-> high_speed_internal_osc_en == $past(periph_hsi_req))
		else $error("stop fast oscillator request ignored");
	stop_slow_a:
		assert property (mode_status == `LPMC_MODE_STOP |-> !low_speed_internal_osc_en
			&& !low_speed_crystal_osc_en && !multispeed_internal_osc_en)
		else $error("stop slow oscillators running");
	stby_power_a:
		assert property (mode_status inside {`LPMC_MODE_STBY_RTC, `LPMC_MODE_STBY}
			|-> !regulator_on && !core_power_on && !pll_en && cpu_reset)
		else $error("standby power still on");
	stby_wake_a:
		assert property (mode_status inside {`LPMC_MODE_STBY_RTC, `LPMC_MODE_STBY}
			&& |(standby_wakeup_pin & ~$past(standby_wakeup_pin))
			|-> ##[1:STBY_LIM] mode_status == `LPMC_MODE_RUN)
		else $error("standby exit too slow");
	ws_range_a:
		assert property (flash_wait_state |-> voltage_range inside {`LPMC_RANGE_1, `LPMC_RANGE_2})
		else $error("wait state in lowest range");
endmodule // lpmc_chk

bind lpmc_ctrl lpmc_chk #(.N_EXT(N_EXT), .STBY_WAKE_CYC(STBY_WAKE_CYC)) chk (.mclk, .rst,
	.periph_irq, .external_interrupt_line, .standby_wakeup_pin, .cpu_clk_en, .periph_clk_en,
	.pll_en, .multispeed_internal_osc_en, .multispeed_low_speed, .high_speed_crystal_osc_en,
	.low_speed_internal_osc_en, .low_speed_crystal_osc_en, .regulator_on, .regulator_low_power,
	.core_power_on, .voltage_range, .flash_wait_state, .mode_status, .periph_hsi_req,
	.high_speed_internal_osc_en, .cpu_reset);
`default_nettype wire

// ### test/lpmc_core_model.sv
// processor core and interrupt source facing the mode controller
`timescale 1ns/10ps
`default_nettype none

module lpmc_core_model (
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic       go,
	input  wire logic       irq_on,
	input  wire logic [7:0] irq_dly,
	input  wire logic       cpu_clk_en,
	output var  logic       cpu_wfi,
	output var  logic       periph_irq
);
	logic [7:0] cnt_q;

	// wfi falls once the core clock is gone, so a stale level cannot re-enter after wake
	always @(posedge mclk)
		if (rst)
		begin
			cpu_wfi <= 1'h0;
			cnt_q <= 8'h00;
			periph_irq <= 1'h0;
		end
		else
		begin
			cpu_wfi <= go || (cpu_wfi && cpu_clk_en);
			cnt_q <= (irq_on && !cpu_clk_en) ? cnt_q + 8'h01 : 8'h00;
			periph_irq <= irq_on && !cpu_clk_en && cnt_q >= irq_dly;
		end
endmodule // lpmc_core_model
`default_nettype wire

// ### test/test_low_power_mode_controller.sv
// self-checking bench for the low-power mode controller
`timescale 1ns/10ps
`default_nettype none
`include "lpmc_defines.vh"

module test_low_power_mode_controller;
	localparam int WK = 50;
	// {gap, addr, data, status}
	localparam logic [51:0] FT [17] = '{52'h1_08_00001f40_20, 52'h1_08_00003e80_60,
		52'h1_08_00007d00_e0, 52'h0_0c_00000007_60, 52'h0_08_00030000_e0, 52'h0_0c_00000007_60,
		52'h0_08_00013e80_10, 52'h1_08_00007d00_50,
		52'h0_08_00003e80_d0, 52'h1_08_00000fa0_d0, 52'h1_08_00003e80_90, 52'h1_08_00001068_90,
		52'h0_08_00031068_b0, 52'h1_08_0000044c_b0, 52'h1_08_0000012c_b0, 52'h1_08_00000083_b0,
		52'h0_00_00000010_b2};
	// {ctrl, mode, wake source}
	localparam logic [15:0] TT [11] = '{16'h11_3_0, 16'h20_1_0, 16'h22_4_4, 16'h22_4_2,
		16'h23_5_1, 16'h23_5_3, 16'h23_5_8, 16'h24_6_7, 16'h24_6_4, 16'h25_7_5, 16'h25_7_6};
	logic        mclk = 1'h0, rst = 1'h1, ce = 1'h1, go = 1'h0, irq_on = 1'h0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, irq_dly = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, r, seed = 32'haa7f681e;
	logic [3:0]  s_axi_wstrb = 4'hf, rtc_evt = 4'h0;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
	logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, cpu_wfi, periph_irq;
	logic [1:0]  s_axi_bresp, s_axi_rresp, comparator_evt = 2'h0, voltage_range;
	logic        external_reset_pin_n = 1'h1, independent_watchdog_rst = 1'h0;
	logic        supply_monitor_output = 1'h0, periph_hsi_req = 1'h0;
	logic [15:0] external_interrupt_line = 16'h0;
	logic [4:0]  periph_wake = 5'h0;
	logic [2:0]  standby_wakeup_pin = 3'h0, mode_status;
	logic        cpu_clk_en, periph_clk_en, pll_en, multispeed_internal_osc_en;
	logic        multispeed_low_speed, high_speed_internal_osc_en, high_speed_crystal_osc_en;
	logic        low_speed_internal_osc_en, low_speed_crystal_osc_en, regulator_on;
	logic        regulator_low_power, core_power_on, flash_wait_state, cpu_reset;
	logic [33:0] q[$];
	int          n_mismatch = 0, checks = 0;

	lpmc_ctrl #(.N_EXT(16), .STBY_WAKE_CYC(WK)) dut (.mclk, .rst, .ce, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpu_wfi, .external_reset_pin_n,
		.independent_watchdog_rst, .external_interrupt_line, .supply_monitor_output,
		.comparator_evt, .periph_wake, .periph_hsi_req, .rtc_evt, .standby_wakeup_pin, .periph_irq,
		.cpu_clk_en, .periph_clk_en, .pll_en, .multispeed_internal_osc_en, .multispeed_low_speed,
		.high_speed_internal_osc_en, .high_speed_crystal_osc_en, .low_speed_internal_osc_en,
		.low_speed_crystal_osc_en, .regulator_on, .regulator_low_power, .core_power_on,
		.voltage_range, .flash_wait_state, .cpu_reset, .mode_status);
	lpmc_core_model core (.mclk, .rst, .go, .irq_on, .irq_dly, .cpu_clk_en, .cpu_wfi,
		.periph_irq);

	always #2.5 mclk = ~mclk;

	function logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task cmp(input logic [33:0] exp, input logic [33:0] got);
		checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask

	// one transfer at a time keeps the note queue in step with the answers
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [33:0] e);
		q.push_back(e);
		@(posedge mclk);
		if (wr)
		begin
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_awvalid <= 1'h1;
			s_axi_wvalid <= 1'h1;
			s_axi_bready <= 1'h1;
		end
		else
		begin
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'h1;
			s_axi_rready <= 1'h1;
		end
		do
		begin
			@(posedge mclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
			if (s_axi_arready)
				s_axi_arvalid <= 1'h0;
		end
		while (!(s_axi_bvalid || s_axi_rvalid));
		s_axi_bready <= 1'h0;
		s_axi_rready <= 1'h0;
	endtask

	always @(posedge mclk)
		if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready))
			cmp(q.pop_front(), s_axi_bvalid ? {s_axi_bresp, 32'h0} : {s_axi_rresp, s_axi_rdata});

	task wait_mode(input logic [2:0] m, input int lim);
		int i;
		for (i = 0; i < lim && mode_status !== m; i++)
			@(posedge mclk);
		cmp({31'h0, m}, {31'h0, mode_status});
	endtask

	task end_of_test();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial
	begin
		repeat (30000) @(posedge mclk);
		n_mismatch++;
		$display("watchdog expired");
		end_of_test();
	end

	initial
	begin
		repeat (16) @(posedge mclk);
		rst <= 1'h0;
		wait_mode(`LPMC_MODE_RUN, 1);
		bus(1'h0, `LPMC_ADDR_STATUS, 32'h0, 34'h20);
		bus(1'h0, `LPMC_ADDR_WAKE_EN, 32'h0, 34'hffff);
		bus(1'h0, 8'h18, 32'h0, {2'h2, 32'h0});
		bus(1'h1, 8'h18, 32'h1, {2'h2, 32'h0});
		$display("reset and map test done");
		foreach (FT[i])
		begin
			if (FT[i][48])
				repeat (1010) @(posedge mclk);
			bus(1'h1, FT[i][47:40], FT[i][39:8], 34'h0);
			bus(1'h0, `LPMC_ADDR_STATUS, 32'h0, {26'h0, FT[i][7:0]});
		end
		$display("frequency step test done");
		foreach (TT[i])
		begin
			r = xs();
			bus(1'h1, `LPMC_ADDR_CTRL, {24'h0, TT[i][15:8]}, 34'h0);
			irq_dly <= {1'h0, r[6:0]};
			irq_on <= TT[i][3:0] == 4'h0;
			periph_hsi_req <= r[8];
			go <= 1'h1;
			@(posedge mclk);
			go <= 1'h0;
			wait_mode(TT[i][7:4], 20);
			if (TT[i][3:0] == 4'h5)
			begin
				rtc_evt <= r[12:9] | 4'h1;
				repeat (WK + 20) @(posedge mclk);
				wait_mode(`LPMC_MODE_STBY, 1);
				rtc_evt <= 4'h0;
			end
			case (TT[i][3:0])
				4'h1: external_interrupt_line <= 16'h1 << r[3:0];
				4'h2: comparator_evt <= r[0] ? 2'h1 : 2'h2;
				4'h3: periph_wake <= 5'h1 << (r % 5);
				4'h4: rtc_evt <= 4'h1 << r[1:0];
				4'h5: standby_wakeup_pin <= 3'h1 << (r % 3);
				4'h6: external_reset_pin_n <= 1'h0;
				4'h7: independent_watchdog_rst <= 1'h1;
				4'h8: supply_monitor_output <= 1'h1;
				default: ;
			endcase
			wait_mode(`LPMC_MODE_RUN, 1000);
			{external_interrupt_line, comparator_evt, periph_wake, rtc_evt} <= 27'h0;
			{standby_wakeup_pin, supply_monitor_output, independent_watchdog_rst} <= 5'h0;
			external_reset_pin_n <= 1'h1;
			irq_on <= 1'h0;
			repeat (4) @(posedge mclk);
			$display("mode test %0d done", i);
		end
		end_of_test();
	end
endmodule // test_low_power_mode_controller
`default_nettype wire
